// *** verilog/qps_map.svh ***
// Purpose: constants for the quad pot serial slave front
// Assumes: included by bare name
// Notes:   offsets, field positions, reset values, counts
`ifndef QPS_MAP_SVH
`define QPS_MAP_SVH
// type code value is arbitrary
`define QPS_TYPE_CODE      4'hA
`define QPS_ID_TYPE_HI     7
`define QPS_ID_TYPE_LO     4
`define QPS_ID_ADDR_HI     1
`define QPS_ID_ADDR_LO     0
`define QPS_INS_OP_HI      7
`define QPS_INS_OP_LO      4
`define QPS_INS_REG_HI     3
`define QPS_INS_REG_LO     2
`define QPS_INS_CH_HI      1
`define QPS_INS_CH_LO      0
`define QPS_OP_RD_WPR      4'h9
`define QPS_OP_WR_WPR      4'hA
`define QPS_OP_RD_SSR      4'hB
`define QPS_OP_WR_SSR      4'hC
`define QPS_OP_XFR_S2W     4'hD
`define QPS_OP_XFR_W2S     4'hE
`define QPS_OP_GXFR_S2W    4'h1
`define QPS_OP_GXFR_W2S    4'h8
`define QPS_OP_INCDEC      4'h2
`define QPS_WIPER_MAX      6'h3F
`define QPS_BOOT_DEFAULT   6'h20
`define QPS_NV_WRITE_NS    10000000
`define QPS_CLK_NS         25
`endif

// *** verilog/qps_pkg.sv ***
// Purpose: types for the quad pot serial slave front
// Assumes: nothing
// Notes:   constants live in qps_map.svh
`default_nettype none
package qps_pkg;
	typedef enum logic [2:0] {
		QPS_ST_ID   = 3'h0,
		QPS_ST_INS  = 3'h1,
		QPS_ST_DATA = 3'h2,
		QPS_ST_RD   = 3'h3,
		QPS_ST_INC  = 3'h4,
		QPS_ST_DONE = 3'h5,
		QPS_ST_DEAF = 3'h6
	} qps_state_t;
	typedef logic [5:0] qps_wiper_t;
endpackage
`default_nettype wire

// *** verilog/qps_cmd_if.sv ***
// Purpose: command strobes from the link domain to the core
// Assumes: toggle crossing, fields stable while toggle settles
// Notes:   none
`default_nettype none
interface qps_cmd_if;
	logic                toggle;
	logic [3:0]          op;
	logic [1:0]          sel_reg;
	logic [1:0]          sel_ch;
	logic [5:0]          data;
	logic [5:0]          rd_wiper [4];
	logic [5:0]          rd_saved [4][4];
	modport link (output toggle, op, sel_reg, sel_ch, data, input rd_wiper, rd_saved);
	modport core (input toggle, op, sel_reg, sel_ch, data, output rd_wiper, rd_saved);
endinterface
`default_nettype wire

// *** verilog/qps_core.sv ***
// Purpose: wiper and saved setting storage for four channels
// Assumes: commands arrive by toggle from the link domain
// Notes:   runs on ref_clk; nonvolatile write modelled by a timer
`default_nettype none
`include "qps_map.svh"
module qps_core #(
	parameter int NV_CYCLES = `QPS_NV_WRITE_NS / `QPS_CLK_NS
) (
	input  wire logic  clk_in,
	input  wire logic  rst_in,
	qps_cmd_if.core    cmd,
	output logic [23:0] wiper_out,
	output logic        nv_busy_out
);
	qps_pkg::qps_wiper_t wiper_r [4];
	qps_pkg::qps_wiper_t wiper_nxt [4];
	qps_pkg::qps_wiper_t saved_r [4][4];
	qps_pkg::qps_wiper_t saved_nxt [4][4];
	logic [2:0]  tog_r;
	logic [31:0] nv_cnt_r;
	logic [31:0] nv_cnt_nxt;
	logic        boot_r;
	logic        go;
	assign go = tog_r[2] ^ tog_r[1];
	always_comb begin
		wiper_nxt  = wiper_r;
		saved_nxt  = saved_r;
		nv_cnt_nxt = (nv_cnt_r != 32'h0) ? nv_cnt_r - 32'h1 : 32'h0;
		if (boot_r) begin
			for (int c = 0; c < 4; c++) wiper_nxt[c] = saved_r[c][0];
		end else if (go) begin
			case (cmd.op)
				`QPS_OP_WR_WPR:  wiper_nxt[cmd.sel_ch] = cmd.data;
				`QPS_OP_INCDEC:  wiper_nxt[cmd.sel_ch] = cmd.data;
				`QPS_OP_XFR_S2W: wiper_nxt[cmd.sel_ch] = saved_r[cmd.sel_ch][cmd.sel_reg];
				`QPS_OP_GXFR_S2W: begin
					for (int c = 0; c < 4; c++) wiper_nxt[c] = saved_r[c][cmd.sel_reg];
				end
				`QPS_OP_WR_SSR: begin
					saved_nxt[cmd.sel_ch][cmd.sel_reg] = cmd.data;
					nv_cnt_nxt = 32'(NV_CYCLES);
				end
				`QPS_OP_XFR_W2S: begin
					saved_nxt[cmd.sel_ch][cmd.sel_reg] = wiper_r[cmd.sel_ch];
					nv_cnt_nxt = 32'(NV_CYCLES);
				end
				`QPS_OP_GXFR_W2S: begin
					for (int c = 0; c < 4; c++) saved_nxt[c][cmd.sel_reg] = wiper_r[c];
					nv_cnt_nxt = 32'(NV_CYCLES);
				end
				default: ;
			endcase
		end
	end
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int c = 0; c < 4; c++) begin
				wiper_r[c] <= 6'h00;
				for (int r = 0; r < 4; r++) saved_r[c][r] <= `QPS_BOOT_DEFAULT;
			end
			tog_r    <= 3'h0;
			nv_cnt_r <= 32'h0;
			boot_r   <= 1'b1;
		end else begin
			wiper_r  <= wiper_nxt;
			saved_r  <= saved_nxt;
			tog_r    <= {tog_r[1:0], cmd.toggle};
			nv_cnt_r <= nv_cnt_nxt;
			boot_r   <= 1'b0;
		end
	end
	always_comb begin
		for (int c = 0; c < 4; c++) begin
			cmd.rd_wiper[c] = wiper_r[c];
			for (int r = 0; r < 4; r++) cmd.rd_saved[c][r] = saved_r[c][r];
			wiper_out[c*6 +: 6] = wiper_r[c];
		end
	end
	assign nv_busy_out = (nv_cnt_r != 32'h0);
endmodule
`default_nettype wire

// *** verilog/qps_link.sv ***
// Purpose: serial shift engine on the host shift clock
// Assumes: host obeys pause timing; select high clears the engine
// Notes:   read data is a snapshot, near-static registers
`default_nettype none
`include "qps_map.svh"
module qps_link (
	input  wire logic       sck_in,
	input  wire logic       rst_in,
	input  wire logic       cs_n_in,
	input  wire logic       si_in,
	input  wire logic       hold_n_in,
	input  wire logic [1:0] device_addr_pins_in,
	qps_cmd_if.link         cmd,
	output logic            so_out,
	output logic            so_oe_out
);
	qps_pkg::qps_state_t st_r, st_nxt;
	logic [2:0] bit_r, bit_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [7:0] rd_r, rd_nxt;
	logic [3:0] op_r, op_nxt;
	logic [1:0] reg_r, reg_nxt, ch_r, ch_nxt;
	logic [5:0] dat_r, dat_nxt;
	logic       tog_r, tog_nxt;
	logic       so_r;
	logic       oe_r;
	logic [7:0] byte_in;
	assign byte_in = {sh_r[6:0], si_in};
	always_comb begin
		st_nxt = st_r; bit_nxt = bit_r + 3'h1; sh_nxt = byte_in; rd_nxt = {rd_r[6:0], 1'b0};
		op_nxt = op_r; reg_nxt = reg_r; ch_nxt = ch_r; dat_nxt = dat_r; tog_nxt = tog_r;
		if (!hold_n_in || st_r == qps_pkg::QPS_ST_DEAF) begin
			bit_nxt = bit_r; sh_nxt = sh_r; rd_nxt = rd_r;
		end else if (bit_r == 3'h7) begin
			case (st_r)
				qps_pkg::QPS_ST_ID: begin
					if (byte_in[`QPS_ID_TYPE_HI:`QPS_ID_TYPE_LO] == `QPS_TYPE_CODE &&
					    byte_in[`QPS_ID_ADDR_HI:`QPS_ID_ADDR_LO] == device_addr_pins_in)
						st_nxt = qps_pkg::QPS_ST_INS;
					else
						st_nxt = qps_pkg::QPS_ST_DEAF;
				end
				qps_pkg::QPS_ST_INS: begin
					op_nxt  = byte_in[`QPS_INS_OP_HI:`QPS_INS_OP_LO];
					reg_nxt = byte_in[`QPS_INS_REG_HI:`QPS_INS_REG_LO];
					ch_nxt  = byte_in[`QPS_INS_CH_HI:`QPS_INS_CH_LO];
					st_nxt  = qps_pkg::QPS_ST_DONE;
					case (byte_in[7:4])
						`QPS_OP_WR_WPR, `QPS_OP_WR_SSR: st_nxt = qps_pkg::QPS_ST_DATA;
						`QPS_OP_INCDEC: begin
							st_nxt  = qps_pkg::QPS_ST_INC;
							dat_nxt = cmd.rd_wiper[byte_in[1:0]];
						end
						`QPS_OP_RD_WPR: begin
							st_nxt = qps_pkg::QPS_ST_RD;
							rd_nxt = {2'b00, cmd.rd_wiper[byte_in[1:0]]};
						end
						`QPS_OP_RD_SSR: begin
							st_nxt = qps_pkg::QPS_ST_RD;
							rd_nxt = {2'b00, cmd.rd_saved[byte_in[1:0]][byte_in[3:2]]};
						end
						`QPS_OP_XFR_S2W, `QPS_OP_XFR_W2S, `QPS_OP_GXFR_S2W,
						`QPS_OP_GXFR_W2S: tog_nxt = ~tog_r;
						default: ;
					endcase
				end
				qps_pkg::QPS_ST_DATA: begin
					dat_nxt = byte_in[5:0];
					tog_nxt = ~tog_r;
					st_nxt  = qps_pkg::QPS_ST_DONE;
				end
				default: ;
			endcase
		end
		if (hold_n_in && st_r == qps_pkg::QPS_ST_INC) begin
			// each clock: input 1 steps up, 0 steps down, clamped at the ends
			if (si_in && dat_r != `QPS_WIPER_MAX) dat_nxt = dat_r + 6'h1;
			else if (!si_in && dat_r != 6'h00) dat_nxt = dat_r - 6'h1;
			tog_nxt = ~tog_r;
		end
	end
	// select high resets the engine; power-up also holds it in reset
	always_ff @(posedge sck_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			st_r <= qps_pkg::QPS_ST_ID; bit_r <= 3'h0; sh_r <= 8'h00; rd_r <= 8'h00;
		end else begin
			st_r <= st_nxt; bit_r <= bit_nxt; sh_r <= sh_nxt; rd_r <= rd_nxt;
		end
	end
	// toggle starts equal to the core's copy, else a false command follows reset
	always_ff @(posedge sck_in or posedge rst_in) begin
		if (rst_in) begin
			op_r  <= 4'h0;
			reg_r <= 2'h0;
			ch_r  <= 2'h0;
			dat_r <= 6'h00;
			tog_r <= 1'b0;
		end else begin
			op_r  <= op_nxt;
			reg_r <= reg_nxt;
			ch_r  <= ch_nxt;
			dat_r <= dat_nxt;
			tog_r <= tog_nxt;
		end
	end
	always_ff @(negedge sck_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			so_r <= 1'b0; oe_r <= 1'b0;
		end else begin
			so_r <= rd_r[7];
			oe_r <= (st_r == qps_pkg::QPS_ST_RD);
		end
	end
	assign cmd.toggle  = tog_r;
	assign cmd.op      = op_r;
	assign cmd.sel_reg = reg_r;
	assign cmd.sel_ch  = ch_r;
	assign cmd.data    = dat_r;
	assign so_out      = so_r;
	// released during a pause, driven again at once on resume
	assign so_oe_out   = oe_r & hold_n_in;
endmodule
`default_nettype wire

// *** verilog/qps_front.sv ***
// Purpose: top of the serial slave front of a quad digital pot
// Assumes: ref_clk 40 MHz; link logic on the host shift clock
// Notes:   link engine reset by select high; core by rst_in
`default_nettype none
`include "qps_map.svh"
module qps_front #(
	parameter int NV_CYCLES = `QPS_NV_WRITE_NS / `QPS_CLK_NS
) (
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	input  wire logic        sck_in,
	input  wire logic        cs_n_in,
	input  wire logic        si_in,
	input  wire logic        hold_n_in,
	input  wire logic [1:0]  device_addr_pins_in,
	output logic             so_out,
	output logic             so_oe_out,
	output logic [23:0]      wiper_out,
	output logic             active_out,
	output logic             nv_busy_out
);
	//----------------------------------------
	// power-up gate and select synchroniser
	//----------------------------------------
	logic [1:0] cs_sync_r;
	logic       armed_r, armed_nxt;
	logic       cs_gated;
	always_comb begin
		armed_nxt = armed_r | cs_sync_r[1];
	end
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cs_sync_r <= 2'b11;
			armed_r   <= 1'b0;
		end else begin
			cs_sync_r <= {cs_sync_r[0], cs_n_in};
			armed_r   <= armed_nxt;
		end
	end
	// armed on the first ref_clk after reset, as the synchroniser resets to select high
	assign cs_gated = cs_n_in | ~armed_r;
	//----------------------------------------
	// link engine and storage
	//----------------------------------------
	qps_cmd_if cmd ();
	qps_link u_link (
		.sck_in              (sck_in),
		.rst_in              (rst_in),
		.cs_n_in             (cs_gated),
		.si_in               (si_in),
		.hold_n_in           (hold_n_in),
		.device_addr_pins_in (device_addr_pins_in),
		.cmd                 (cmd.link),
		.so_out              (so_out),
		.so_oe_out           (so_oe_out)
	);
	qps_core #(.NV_CYCLES(NV_CYCLES)) u_core (
		.clk_in      (ref_clk_in),
		.rst_in      (rst_in),
		.cmd         (cmd.core),
		.wiper_out   (wiper_out),
		.nv_busy_out (nv_busy_out)
	);
	// active when selected or a nonvolatile write runs
	assign active_out = ~cs_sync_r[1] | nv_busy_out;
endmodule
`default_nettype wire

// *** testbench/qps_front_sva.sv ***
// Purpose: port checks for qps_front
// Assumes: sck far slower than ref_clk
// Notes:   bound below
`default_nettype none
module qps_front_sva #(
	parameter int NV_CYCLES = 20
) (
	input wire logic        ref_clk_in,
	input wire logic        rst_in,
	input wire logic        sck_in,
	input wire logic        cs_n_in,
	input wire logic        si_in,
	input wire logic        hold_n_in,
	input wire logic [1:0]  device_addr_pins_in,
	input wire logic        so_out,
	input wire logic        so_oe_out,
	input wire logic [23:0] wiper_out,
	input wire logic        active_out,
	input wire logic        nv_busy_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// busy length counter
	// ----
	int busy_cnt_r;
	int busy_cnt_nxt;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	always_comb busy_cnt_nxt = nv_busy_out ? busy_cnt_r + 1 : 0;
	always_ff @(posedge ref_clk_in or posedge rst_in)
		if (rst_in) busy_cnt_r <= 0;
		else busy_cnt_r <= busy_cnt_nxt;
	oe_off_a: assert property (cs_n_in [*2] |-> !so_oe_out)
		else $error("so driven while deselected");
	so_edge_a: assert property (so_oe_out && $past(so_oe_out) && $changed(so_out) |-> !sck_in)
		else $error("so changed outside sck low");
	boot_load_a: assert property ($fell(rst_in) |-> ##[1:3] wiper_out == {4{6'h20}})
		else $error("boot wiper not loaded");
	busy_active_a: assert property (nv_busy_out |-> active_out)
		else $error("standby during write");
	select_active_a: assert property (!cs_n_in [*4] |-> active_out)
		else $error("selected but not active");
	idle_standby_a: assert property (cs_n_in [*4] ##0 !nv_busy_out && !$past(nv_busy_out) |-> !active_out)
		else $error("active while idle");
	hold_freeze_a: assert property (!hold_n_in [*2] |-> $stable(so_out))
		else $error("so moved during pause");
	nv_bound_a: assert property (busy_cnt_r <= NV_CYCLES + 4)
		else $error("write busy too long");
	wiper_quiet_a: assert property (cs_n_in [*8] ##0 $stable(wiper_out) |=> $stable(wiper_out))
		else $error("wiper moved while idle");
endmodule
bind qps_front qps_front_sva #(.NV_CYCLES(NV_CYCLES)) u_sva (.ref_clk_in(ref_clk_in),
	.rst_in(rst_in), .sck_in(sck_in), .cs_n_in(cs_n_in), .si_in(si_in), .hold_n_in(hold_n_in),
	.device_addr_pins_in(device_addr_pins_in), .so_out(so_out), .so_oe_out(so_oe_out),
	.wiper_out(wiper_out), .active_out(active_out), .nv_busy_out(nv_busy_out));
`default_nettype wire

// *** testbench/qps_host_model.sv ***
// Purpose: serial bus master driving the front
// Assumes: sck period 80 ns, idle low
// Notes:   released lines show inverted last value
`default_nettype none
module qps_host_model (
	output logic      sck_out,
	output logic      cs_n_out,
	output logic      si_out,
	output logic      hold_n_out,
	input  wire logic so_in,
	input  wire logic so_oe_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx;
	event       got;
	initial begin
		rx = 8'h00;
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		si_out = 1'b0;
		hold_n_out = 1'b1;
	end
	// ----
	// one frame, optional pause before bit hold_at
	// ----
	task automatic xfer(input logic [23:0] tx, input int nbits, input int hold_at);
		cs_n_out = 1'b0;
		#40;
		for (int i = 0; i < nbits; i++) begin
			if (i == hold_at) begin
				hold_n_out = 1'b0;
				repeat (2) begin
					si_out = ~si_out;
					#40 sck_out = 1'b1;
					#40 sck_out = 1'b0;
				end
				hold_n_out = 1'b1;
			end
			si_out = tx[23 - i];
			#40 sck_out = 1'b1;
			rx = {rx[6:0], so_oe_in ? so_in : ~rx[0]};
			#40 sck_out = 1'b0;
		end
		#40 cs_n_out = 1'b1;
		si_out = ~si_out;
		->got;
		#200;
	endtask
endmodule
`default_nettype wire

// *** testbench/test_qps_front.sv ***
// Purpose: self-checking bench for qps_front
// Assumes: host model drives the serial side
// Notes:   read results checked by a queue monitor
`default_nettype none
`include "qps_map.svh"
module test_qps_front;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk_in;
	logic        rst_in;
	logic [1:0]  device_addr_pins_in;
	wire logic   sck, cs_n, si, hold_n, so, so_oe, act, busy;
	wire logic [23:0] wiper;
	int          miscompares;
	int          tests_run;
	int          seed;
	logic [7:0]  exp_q [$];
	logic [5:0]  v;
	logic [5:0]  w [4];
	logic [5:0]  s [4][4];
	qps_front #(.NV_CYCLES(20)) dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .sck_in(sck),
		.cs_n_in(cs_n), .si_in(si), .hold_n_in(hold_n), .device_addr_pins_in(device_addr_pins_in),
		.so_out(so), .so_oe_out(so_oe), .wiper_out(wiper), .active_out(act), .nv_busy_out(busy));
	qps_host_model host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .hold_n_out(hold_n),
		.so_in(so), .so_oe_in(so_oe));
	// ----
	// helpers
	// ----
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [23:0] op(input logic [3:0] code, input logic [1:0] r, c, a,
		input logic [5:0] d);
		return {`QPS_TYPE_CODE, 2'h0, a, code, r, c, 2'h0, d};
	endfunction
	task automatic wchk();
		check("wiper", wiper, {w[3], w[2], w[1], w[0]});
	endtask
	task automatic idle();
		check("busy", {23'h0, busy}, 24'h1);
		check("active", {23'h0, act}, 24'h1);
		for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge ref_clk_in);
		check("busy", {23'h0, busy}, 24'h0);
		check("active", {23'h0, act}, 24'h0);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		ref_clk_in = 1'b0;
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end
	initial begin
		#500000;
		miscompares++;
		print_verdict();
	end
	initial forever begin
		@(host.got);
		if (exp_q.size() != 0) check("read", {16'h0, host.rx}, {16'h0, exp_q.pop_front()});
	end
	// ----
	// main sequence
	// ----
	initial begin
		seed = 63;
		rst_in = 1'b1;
		device_addr_pins_in = 2'h0;
		for (int i = 0; i < 16; i++) s[i / 4][i % 4] = 6'h20;
		repeat (2) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge ref_clk_in);
		#13;
		w = '{4{6'h20}};
		wchk();
		check("oe", {23'h0, so_oe}, 24'h0);
		for (int c = 0; c < 4; c++) begin
			@(posedge ref_clk_in) device_addr_pins_in <= c[1:0];
			v = $random(seed);
			w[c] = v;
			host.xfer(op(`QPS_OP_WR_WPR, 0, c, c, v), 24, c * 5 - 1);
			wchk();
			exp_q.push_back({2'h0, v});
			host.xfer(op(`QPS_OP_RD_WPR, 0, c, c, 0), 24, 20);
		end
		for (int r = 0; r < 4; r++) begin
			v = $random(seed);
			s[1][r] = v;
			host.xfer(op(`QPS_OP_WR_SSR, r, 1, 3, v), 24, -1);
			idle();
			exp_q.push_back({2'h0, v});
			host.xfer(op(`QPS_OP_RD_SSR, r, 1, 3, 0), 24, -1);
			host.xfer(op(`QPS_OP_XFR_S2W, r, 1, 3, 0), 16, -1);
			w[1] = v;
			wchk();
		end
		host.xfer(op(`QPS_OP_XFR_W2S, 3, 2, 3, 0), 16, -1);
		s[2][3] = w[2];
		idle();
		host.xfer(op(`QPS_OP_WR_WPR, 0, 0, 2, 6'h3F), 24, -1);
		host.xfer(op(`QPS_OP_WR_WPR, 0, 0, 3, 6'h3F) ^ 24'h800000, 24, -1);
		host.xfer(op(`QPS_OP_WR_WPR, 0, 0, 3, 6'h3F), 12, -1);
		wchk();
		host.xfer(op(`QPS_OP_GXFR_W2S, 0, 0, 3, 0), 16, -1);
		for (int c = 0; c < 4; c++) s[c][0] = w[c];
		idle();
		host.xfer(op(`QPS_OP_GXFR_S2W, 3, 0, 3, 0), 16, -1);
		for (int c = 0; c < 4; c++) w[c] = s[c][3];
		wchk();
		// step bits 00111111: two down, six up, clamped at both ends
		host.xfer(op(`QPS_OP_INCDEC, 0, 2, 3, 6'h3F), 24, -1);
		for (int i = 0; i < 8; i++) begin
			if (i < 2) w[2] = (w[2] != 6'h00) ? w[2] - 6'h1 : w[2];
			else w[2] = (w[2] != `QPS_WIPER_MAX) ? w[2] + 6'h1 : w[2];
		end
		wchk();
		exp_q.push_back({2'h0, s[2][0]});
		host.xfer(op(`QPS_OP_RD_SSR, 0, 2, 3, 0), 24, -1);
		// second power-up in mid-run
		@(posedge ref_clk_in) rst_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge ref_clk_in);
		w = '{4{`QPS_BOOT_DEFAULT}};
		wchk();
		exp_q.push_back({2'h0, `QPS_BOOT_DEFAULT});
		host.xfer(op(`QPS_OP_RD_SSR, 0, 2, 3, 0), 24, -1);
		print_verdict();
	end
endmodule
`default_nettype wire
